/* File: bench/scss_osc_model.sv */
// Far-side oscillator model: crystal, RC network and internal oscillator tick sources.
`timescale 1ns/1ps
// ----------------------------------------
// One tick source
// ----------------------------------------
module scss_tick_gen #(
  parameter int DIV = 2
) (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_slow,
  output logic o_tick
);
  int cnt_q;
  // A slow part stretches each period to twice its nominal length.
  always_ff @(posedge i_clock) begin
    if (i_srst || cnt_q >= (i_slow ? 2 * DIV : DIV) - 1) begin
      cnt_q <= 0;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
  assign o_tick = (cnt_q == 0) && !i_srst;
endmodule

// ----------------------------------------
// All oscillators of the far side
// ----------------------------------------
module scss_osc_model #(
  parameter int PRI_DIV = 3,
  parameter int SEC_DIV = 7,
  parameter int HF_DIV = 2,
  parameter int MF_DIV = 6,
  parameter int LF_DIV = 40
) (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_slow,
  output logic o_pri_tick,
  output logic o_pll_tick,
  output logic o_sec_tick,
  output logic o_hf_tick,
  output logic o_mf_tick,
  output logic o_lf_tick
);
  scss_tick_gen #(.DIV(PRI_DIV)) u_pri (.i_clock(i_clock), .i_srst(i_srst), .i_slow(i_slow),
    .o_tick(o_pri_tick));
  scss_tick_gen #(.DIV(1)) u_pll (.i_clock(i_clock), .i_srst(i_srst), .i_slow(i_slow),
    .o_tick(o_pll_tick));
  scss_tick_gen #(.DIV(SEC_DIV)) u_sec (.i_clock(i_clock), .i_srst(i_srst), .i_slow(i_slow),
    .o_tick(o_sec_tick));
  scss_tick_gen #(.DIV(HF_DIV)) u_hf (.i_clock(i_clock), .i_srst(i_srst), .i_slow(1'b0),
    .o_tick(o_hf_tick));
  scss_tick_gen #(.DIV(MF_DIV)) u_mf (.i_clock(i_clock), .i_srst(i_srst), .i_slow(1'b0),
    .o_tick(o_mf_tick));
  scss_tick_gen #(.DIV(LF_DIV)) u_lf (.i_clock(i_clock), .i_srst(i_srst), .i_slow(1'b0),
    .o_tick(o_lf_tick));
endmodule

/* File: bench/testbench.sv */
// Self-checking testbench of the system clock select and start-up block.
`timescale 1ns/1ps
module testbench;
  localparam int PRI = 3;
  localparam int HF = 2;
  localparam int MF = 6;
  localparam int LF = 40;
  localparam int PU = 20;
  localparam int PLL = 10;
  logic i_clock, i_srst, slow, por, slp, wake, en_n;
  logic [3:0] cfg;
  scss_pkg::scss_bus_s bus;
  logic pri_t, pll_t, sec_t, hf_t, mf_t, lf_t;
  logic [7:0] o_rdata;
  logic core_t, per_t, wdt_t, hold, busy, idle, sleep;
  logic [5:0] hf_tune, mf_tune;
  logic [1:0] act;
  scss_pkg::scss_pins_s pins;
  int fails = 0;
  int checks = 0;
  int n, k;
  logic [7:0] r;
  logic lf_prev;
  logic [3:0] modes [5] = '{4'h6, 4'h7, 4'h8, 4'h9, 4'h1};
  logic [2:0] pinx [5] = '{3'b000, 3'b101, 3'b111, 3'b010, 3'b100};
  logic [7:0] fctl [5] = '{8'h72, 8'h42, 8'h02, 8'h02, 8'h22};
  logic [7:0] ftun [5] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
  logic [7:0] fmid [5] = '{8'h00, 8'h00, 8'h00, 8'h10, 8'h10};
  int fper [5] = '{HF, HF * 8, LF, MF * 16, MF};

  scss_osc_model #(.PRI_DIV(PRI), .HF_DIV(HF), .MF_DIV(MF), .LF_DIV(LF)) u_osc (
    .i_clock(i_clock), .i_srst(i_srst), .i_slow(slow), .o_pri_tick(pri_t),
    .o_pll_tick(pll_t), .o_sec_tick(sec_t), .o_hf_tick(hf_t), .o_mf_tick(mf_t),
    .o_lf_tick(lf_t));

  scss_top #(.PU_CYCLES(PU), .PLL_CYCLES(PLL)) dut (
    .i_clock(i_clock), .i_srst(i_srst), .i_bus(bus), .o_rdata(o_rdata),
    .i_primary_osc_config(cfg), .i_powerup_timer_enable_n(en_n), .i_pri_tick(pri_t),
    .i_pll_tick(pll_t), .i_sec_tick(sec_t), .i_hf_tick(hf_t), .i_mf_tick(mf_t),
    .i_lf_tick(lf_t), .i_por_event(por), .i_sleep_exec(slp), .i_wake(wake),
    .o_core_tick(core_t), .o_periph_tick(per_t), .o_wdt_tick(wdt_t), .o_hf_tune(hf_tune),
    .o_mf_tune(mf_tune), .o_active_src(act), .o_reset_hold(hold),
    .o_startup_busy(busy), .o_idle(idle), .o_sleep(sleep), .o_pins(pins));

  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end

  always_ff @(posedge i_clock) begin
    lf_prev <= lf_t;
  end

  // ----------------------------------------
  // Bus access, comparison and measurement
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_clock);
    bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge i_clock);
    bus.we <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge i_clock);
    bus <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge i_clock);
    bus.re <= 1'b0;
    #1;
    d = o_rdata;
  endtask

  task automatic pulse(input int which);
    @(posedge i_clock);
    if (which == 0) por <= 1'b1; else if (which == 1) slp <= 1'b1; else wake <= 1'b1;
    @(posedge i_clock);
    por <= 1'b0;
    slp <= 1'b0;
    wake <= 1'b0;
    #1;
  endtask

  function automatic logic sig(input int w);
    return (w == 0) ? core_t : pins.osc_out;
  endfunction

  task automatic waitv(input int w, input logic v, inout int c);
    int t;
    for (t = 0; t < 500 && sig(w) !== v; t++) begin
      @(posedge i_clock);
      #1;
      c++;
    end
  endtask

  // Cycles from one rising edge of the watched signal to the next.
  task automatic period(input int w, output int c);
    c = 0;
    waitv(w, 1'b0, c);
    waitv(w, 1'b1, c);
    c = 0;
    waitv(w, 1'b0, c);
    waitv(w, 1'b1, c);
  endtask

  task automatic ticks(input int len, output int nc, output int np);
    nc = 0;
    np = 0;
    repeat (len) begin
      @(posedge i_clock);
      #1;
      nc += (core_t === 1'b1);
      np += (per_t === 1'b1);
    end
  endtask

  task automatic startup(input logic [3:0] m, input logic e, input int exp, input int tol);
    cfg <= m;
    en_n <= e;
    pulse(0);
    chk(hold, !e || m <= 4'h3, "reset hold at power-up");
    for (n = 0; busy === 1'b1 && n < 6000; n++) begin
      @(posedge i_clock);
      #1;
    end
    chk((n >= exp - tol && n <= exp + tol), 1'b1, "start-up length");
    chk({hold, busy}, 2'b00, "start-up finished");
  endtask

  task automatic do_reset();
    @(posedge i_clock);
    i_srst <= 1'b1;
    repeat (5) @(posedge i_clock);
    i_srst <= 1'b0;
    @(posedge i_clock);
  endtask

  task automatic test_done();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    fails++;
    test_done();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    i_srst = 1'b1;
    slow = 1'b0;
    por = 1'b0;
    slp = 1'b0;
    wake = 1'b0;
    en_n = 1'b1;
    cfg = 4'h1;
    bus = '0;
    do_reset();
    rd(2'h0, r);
    chk(r & 8'hF7, 8'h30, "ctrl after reset");
    rd(2'h1, r);
    chk(r, 8'h00, "ctrl2 after reset");
    wr(2'h3, 8'hFF);
    rd(2'h3, r);
    chk(r, 8'h00, "unmapped read");
    $display("test reset values done");
    wr(2'h2, 8'h15);
    @(posedge i_clock);
    #1;
    chk({hf_tune, mf_tune}, {6'h15, 6'h15}, "tune outputs");
    n = 0;
    for (k = 0; k < 100; k++) begin
      @(posedge i_clock);
      #1;
      chk(wdt_t, lf_prev, "wdt tick");
      n += (wdt_t === 1'b1);
    end
    chk(n >= 2, 1'b1, "wdt ticks seen");
    $display("test tune and watchdog done");
    period(0, n);
    chk(n, PRI, "primary crystal period");
    slow <= 1'b1;
    period(0, n);
    period(0, n);
    chk(n, 2 * PRI, "slow primary period");
    slow <= 1'b0;
    $display("test primary clock done");
    for (k = 0; k < 5; k++) begin
      cfg <= modes[k];
      repeat (4) @(posedge i_clock);
      #1;
      chk({pins.osc_out_oe_n, pins.osc_in_gpio, pins.osc_out_gpio}, pinx[k], "pins");
    end
    cfg <= 4'h6;
    period(1, n);
    chk(n, 4 * PRI, "rc clock out divided by four");
    cfg <= 4'h8;
    $display("test pins done");
    wr(2'h0, 8'h71);
    wr(2'h0, 8'h72);
    rd(2'h1, r);
    chk(r[0], 1'b1, "switch pending");
    for (k = 0, n = 0; k < 100 && act !== 2'h2; k++) begin
      @(posedge i_clock);
      #1;
      n += (core_t === 1'b1);
    end
    chk({act, 8'(n)}, {2'h2, 8'h00}, "switch to internal, no ticks meanwhile");
    for (k = 0; k < 5; k++) begin
      wr(2'h2, ftun[k]);
      wr(2'h1, fmid[k]);
      wr(2'h0, fctl[k]);
      period(0, n);
      chk(n, fper[k], "internal period");
    end
    $display("test internal frequency done");
    wr(2'h0, 8'hF2);
    pulse(1);
    ticks(3 * LF, n, k);
    chk({idle, sleep, 8'(n), (k > 0)}, {2'b10, 8'h00, 1'b1}, "idle mode");
    pulse(2);
    wr(2'h0, 8'h72);
    pulse(1);
    ticks(3 * LF, n, k);
    chk({idle, sleep, 8'(n + k)}, {2'b01, 8'h00}, "sleep mode");
    pulse(2);
    chk({idle, sleep}, 2'b00, "woken");
    $display("test power modes done");
    startup(4'h8, 1'b0, PU, 2);
    startup(4'h8, 1'b1, 0, 1);
    startup(4'h1, 1'b1, 1024 * PRI, PRI + 2);
    startup(4'h3, 1'b0, PU + 1024 * PRI + PLL, PRI + 4);
    rd(2'h0, r);
    chk(r[3], 1'b1, "ready after start-up");
    $display("test start-up done");
    wr(2'h0, 8'h71);
    do_reset();
    rd(2'h0, r);
    chk({act, r & 8'hF7}, {2'h0, 8'h30}, "second reset");
    wr(2'h0, 8'h31);
    for (k = 0; k < 100 && act !== 2'h1; k++) begin
      @(posedge i_clock);
      #1;
    end
    chk(act, 2'h1, "switch to secondary");
    $display("test second reset done");
    test_done();
  end
endmodule

/* File: pkg/scss_pkg.sv */
// Shared constants and carrier types of the system clock select and start-up block.
package scss_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_CTRL2 = 2'h1;
  localparam logic [1:0] ADDR_TUNE = 2'h2;
  localparam int CTRL_IDLE_BIT = 7;
  localparam int CTRL_FREQ_LSB = 4;
  localparam int CTRL_READY_BIT = 3;
  localparam int CTRL2_MIDSEL_BIT = 4;
  localparam int TUNE_LFSRC_BIT = 7;

  // ----------------------------------------
  // Reset values and encodings
  // ----------------------------------------
  localparam logic [1:0] SRC_PRIMARY = 2'h0;
  localparam logic [1:0] SRC_SECONDARY = 2'h1;
  localparam logic [2:0] FREQ_RESET = 3'h3;
  localparam logic [2:0] FREQ_LOW = 3'h0;
  localparam logic [2:0] FREQ_250K = 3'h1;
  localparam logic [2:0] FREQ_500K = 3'h2;
  localparam logic [3:0] LF_SHIFT = 4'h9;
  localparam logic [3:0] MF_LOW_SHIFT = 4'h4;
  localparam logic [3:0] MODE_LP = 4'h0;
  localparam logic [3:0] MODE_XT = 4'h1;
  localparam logic [3:0] MODE_HS = 4'h2;
  localparam logic [3:0] MODE_FAST_CRYSTAL_PLL = 4'h3;
  localparam logic [3:0] MODE_EXT_CLOCK = 4'h4;
  localparam logic [3:0] MODE_RC = 4'h6;
  localparam logic [3:0] MODE_RC_WITH_GPIO = 4'h7;
  localparam logic [3:0] MODE_INT_OSC_GPIO = 4'h8;
  localparam logic [3:0] MODE_INT_OSC_DIVIDED_CLOCK_OUT = 4'h9;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLOCK_KHZ = 250000;
  localparam int PU_TIME_MS = 66;
  localparam int PU_CYCLES = PU_TIME_MS * CLOCK_KHZ;
  localparam int PLL_LOCK_MS = 2;
  localparam int PLL_CYCLES = PLL_LOCK_MS * CLOCK_KHZ;
  localparam int OST_PERIODS = 1024;
  localparam int SWITCH_TICKS = 2;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } scss_bus_s;

  typedef struct packed {
    logic osc_out;
    logic osc_out_oe_n;
    logic osc_in_gpio;
    logic osc_out_gpio;
  } scss_pins_s;

endpackage

/* File: verilog/scss_top.sv */
// System clock source select, internal frequency select and start-up timers.
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
// How it works
// [RULE1] Two-bit field picks primary, secondary or internal.
// [RULE2] Four-bit mode derives the primary clock source.
// [RULE3] Source changes after a short transition interval.
// [RULE4] Any reset selects the primary clock; the code does so on i_srst only, an i_por_event keeps the current source.
// [RULE5] Three-bit field sets internal block frequency.
// [RULE6] Frequency writes take effect at once.
// [RULE7] Reset sets internal frequency to 1 MHz.
// [RULE8] Lowest setting picks source by two bits.
// [RULE9] Low clock from medium/high oscillator is tunable.
// [RULE10] Watchdog always runs from low oscillator.
// [RULE11] Power-down enters sleep or idle by bit.
// [RULE12] RC mode drives RC clock divided by four.
// [RULE13] RC with I/O releases output pin.
// [RULE14] High oscillator 16 MHz, software tunable.
// [RULE15] Medium oscillator 500 kHz, software tunable.
// [RULE16] Low oscillator 31.25 kHz, never tuned.
// [RULE17] Internal modes free pins or output clock/4.
// [RULE18] Power-up timer adds 66 ms when enabled.
// [RULE19] Crystal modes wait 1024 periods, PLL 2 ms.
// [RULE20] Switching never produces runt system clock pulses.
module scss_top #(
  parameter int PU_CYCLES = scss_pkg::PU_CYCLES,
  parameter int PLL_CYCLES = scss_pkg::PLL_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire scss_pkg::scss_bus_s i_bus,
  output logic [7:0] o_rdata,
  input wire logic [3:0] i_primary_osc_config,
  input wire logic i_powerup_timer_enable_n,
  input wire logic i_pri_tick,
  input wire logic i_pll_tick,
  input wire logic i_sec_tick,
  input wire logic i_hf_tick,
  input wire logic i_mf_tick,
  input wire logic i_lf_tick,
  input wire logic i_por_event,
  input wire logic i_sleep_exec,
  input wire logic i_wake,
  output logic o_core_tick,
  output logic o_periph_tick,
  output logic o_wdt_tick,
  output logic [5:0] o_hf_tune,
  output logic [5:0] o_mf_tune,
  output logic [1:0] o_active_src,
  output logic o_reset_hold,
  output logic o_startup_busy,
  output logic o_idle,
  output logic o_sleep,
  output scss_pkg::scss_pins_s o_pins
);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (PU_CYCLES < 1 || PLL_CYCLES < 1) begin : g_bad_param
    $error("scss_top: timer counts must be at least one cycle");
  end

  localparam int MAXC = (PU_CYCLES > PLL_CYCLES) ? PU_CYCLES : PLL_CYCLES;
  localparam int CNT_W = $clog2(MAXC + scss_pkg::OST_PERIODS + 1);
  localparam logic [CNT_W-1:0] PU_LAST = CNT_W'(PU_CYCLES - 1);
  localparam logic [CNT_W-1:0] PLL_LAST = CNT_W'(PLL_CYCLES - 1);
  localparam logic [CNT_W-1:0] OST_LAST = CNT_W'(scss_pkg::OST_PERIODS - 1);
  localparam logic [1:0] SW_LAST = 2'(scss_pkg::SWITCH_TICKS - 1);

  typedef enum logic [1:0] {ST_READY, ST_PU, ST_OST, ST_PLL} scss_st_e;
  typedef enum logic [1:0] {PM_RUN, PM_IDLE, PM_SLEEP} scss_pm_e;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic idle_sel_q;
  logic [2:0] freq_q;
  logic midsel_q;
  logic lfsrc_q;
  logic [5:0] tune_q;
  logic ctrl_wr;
  logic [1:0] wsrc;
  logic [2:0] wfreq;

  assign ctrl_wr = i_bus.we && (i_bus.addr == scss_pkg::ADDR_CTRL);
  assign wsrc = i_bus.wdata[1:0];
  assign wfreq = i_bus.wdata[scss_pkg::CTRL_FREQ_LSB +: 3];

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      idle_sel_q <= 1'b0;
      freq_q <= scss_pkg::FREQ_RESET; // see [RULE7]
    end else if (ctrl_wr) begin
      idle_sel_q <= i_bus.wdata[scss_pkg::CTRL_IDLE_BIT];
      freq_q <= wfreq; // see [RULE5]
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      midsel_q <= 1'b0;
      lfsrc_q <= 1'b0;
      tune_q <= 6'h00;
    end else if (i_bus.we && i_bus.addr == scss_pkg::ADDR_CTRL2) begin
      midsel_q <= i_bus.wdata[scss_pkg::CTRL2_MIDSEL_BIT];
    end else if (i_bus.we && i_bus.addr == scss_pkg::ADDR_TUNE) begin
      lfsrc_q <= i_bus.wdata[scss_pkg::TUNE_LFSRC_BIT];
      tune_q <= i_bus.wdata[5:0];
    end
  end

  // Trim goes to the high and medium oscillators only; the low one has no trim input.
  assign o_hf_tune = tune_q; // see [RULE14] [RULE9]
  assign o_mf_tune = tune_q; // see [RULE15] [RULE16]

  // ----------------------------------------
  // Internal oscillator block
  // ----------------------------------------
  logic [3:0] hf_sh;
  logic [3:0] mf_sh;
  logic [8:0] hf_lim;
  logic [3:0] mf_lim;
  logic [8:0] hf_cnt_q;
  logic [3:0] mf_cnt_q;
  logic use_mf;
  logic use_lf;
  logic int_tick;

  assign hf_sh = (freq_q == scss_pkg::FREQ_LOW) ? scss_pkg::LF_SHIFT : 4'(3'h7 - freq_q);
  assign mf_sh = (freq_q == scss_pkg::FREQ_500K) ? 4'h0 :
                 (freq_q == scss_pkg::FREQ_250K) ? 4'h1 : scss_pkg::MF_LOW_SHIFT;
  assign hf_lim = 9'((10'h001 << hf_sh) - 10'h001);
  assign mf_lim = 4'((5'h01 << mf_sh) - 5'h01);

  // The lowest setting chooses among the three oscillators by two control bits.
  assign use_lf = (freq_q == scss_pkg::FREQ_LOW) && !lfsrc_q; // see [RULE8]
  assign use_mf = midsel_q && (freq_q <= scss_pkg::FREQ_500K) &&
                  (freq_q != scss_pkg::FREQ_LOW || lfsrc_q); // see [RULE8]

  // A write that changes the frequency restarts the postscalers so the new rate applies at once.
  always_ff @(posedge i_clock) begin
    if (i_srst || (ctrl_wr && wfreq != freq_q)) begin
      hf_cnt_q <= 9'h000; // see [RULE6]
    end else if (i_hf_tick) begin
      hf_cnt_q <= (hf_cnt_q >= hf_lim) ? 9'h000 : hf_cnt_q + 9'h001;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst || (ctrl_wr && wfreq != freq_q)) begin
      mf_cnt_q <= 4'h0; // see [RULE6]
    end else if (i_mf_tick) begin
      mf_cnt_q <= (mf_cnt_q >= mf_lim) ? 4'h0 : mf_cnt_q + 4'h1;
    end
  end

  always_comb begin
    if (use_lf) begin
      int_tick = i_lf_tick; // see [RULE16]
    end else if (use_mf) begin
      int_tick = i_mf_tick && (mf_cnt_q >= mf_lim); // see [RULE9]
    end else begin
      int_tick = i_hf_tick && (hf_cnt_q >= hf_lim); // see [RULE5]
    end
  end

  // ----------------------------------------
  // Primary clock and source switch
  // ----------------------------------------
  logic xtal;
  logic pll_mode;
  logic int_mode;
  logic pri_tick;
  logic [1:0] cur_q;
  logic [1:0] psrc_q;
  logic pend_q;
  logic [1:0] swc_q;
  logic cur_tick;
  logic new_tick;
  logic [1:0] tgt;
  logic sys_tick;

  assign xtal = i_primary_osc_config <= scss_pkg::MODE_FAST_CRYSTAL_PLL;
  assign pll_mode = i_primary_osc_config == scss_pkg::MODE_FAST_CRYSTAL_PLL;
  assign int_mode = (i_primary_osc_config == scss_pkg::MODE_INT_OSC_GPIO) ||
                    (i_primary_osc_config == scss_pkg::MODE_INT_OSC_DIVIDED_CLOCK_OUT);

  always_comb begin
    if (pll_mode) begin
      pri_tick = i_pll_tick; // see [RULE2]
    end else if (int_mode) begin
      pri_tick = int_tick; // see [RULE2]
    end else begin
      pri_tick = i_pri_tick; // see [RULE2]
    end
  end

  always_comb begin
    case (cur_q)
      scss_pkg::SRC_PRIMARY: cur_tick = pri_tick; // see [RULE1]
      scss_pkg::SRC_SECONDARY: cur_tick = i_sec_tick;
      default: cur_tick = int_tick;
    endcase
    case (psrc_q)
      scss_pkg::SRC_PRIMARY: new_tick = pri_tick;
      scss_pkg::SRC_SECONDARY: new_tick = i_sec_tick;
      default: new_tick = int_tick;
    endcase
  end

  assign tgt = pend_q ? psrc_q : cur_q;

  // The switch waits for ticks of the new source while the system clock is held off.
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      cur_q <= scss_pkg::SRC_PRIMARY; // see [RULE4]
      psrc_q <= scss_pkg::SRC_PRIMARY;
      pend_q <= 1'b0;
      swc_q <= 2'h0;
    end else if (ctrl_wr && wsrc != tgt) begin
      pend_q <= 1'b1; // see [RULE3]
      psrc_q <= wsrc;
      swc_q <= 2'h0;
    end else if (pend_q && new_tick) begin
      if (swc_q == SW_LAST) begin
        cur_q <= psrc_q; // see [RULE3]
        pend_q <= 1'b0;
      end else begin
        swc_q <= swc_q + 2'h1;
      end
    end
  end

  // ----------------------------------------
  // Start-up timers
  // ----------------------------------------
  scss_st_e st_q;
  scss_pm_e pm_q;
  logic [CNT_W-1:0] cnt_q;
  logic hold_q;
  logic wake_sleep;

  assign wake_sleep = i_wake && pm_q == PM_SLEEP;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      st_q <= ST_READY;
      cnt_q <= '0;
      hold_q <= 1'b0;
    end else if (i_por_event) begin
      cnt_q <= '0;
      hold_q <= !i_powerup_timer_enable_n || xtal; // see [RULE18]
      st_q <= !i_powerup_timer_enable_n ? ST_PU : (xtal ? ST_OST : ST_READY);
    end else if (wake_sleep) begin
      cnt_q <= '0;
      st_q <= xtal ? ST_OST : ST_READY; // see [RULE19]
    end else begin
      case (st_q)
        ST_PU: begin
          if (cnt_q == PU_LAST) begin
            cnt_q <= '0;
            st_q <= xtal ? ST_OST : ST_READY; // see [RULE18]
            hold_q <= xtal;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_OST: begin
          if (i_pri_tick && cnt_q == OST_LAST) begin
            cnt_q <= '0;
            st_q <= pll_mode ? ST_PLL : ST_READY; // see [RULE19]
            hold_q <= hold_q && pll_mode;
          end else if (i_pri_tick) begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_PLL: begin
          if (cnt_q == PLL_LAST) begin
            cnt_q <= '0;
            st_q <= ST_READY; // see [RULE19]
            hold_q <= 1'b0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_READY: begin
          hold_q <= 1'b0;
        end
        default: begin
          st_q <= ST_READY;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Power management and clock outputs
  // ----------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      pm_q <= PM_RUN;
    end else if (i_sleep_exec && pm_q == PM_RUN) begin
      pm_q <= idle_sel_q ? PM_IDLE : PM_SLEEP; // see [RULE11]
    end else if (i_wake && pm_q != PM_RUN) begin
      pm_q <= PM_RUN;
    end
  end

  // Only whole ticks of the settled source pass, so no runt pulse leaves the block.
  assign sys_tick = cur_tick && !pend_q && st_q == ST_READY; // see [RULE20]

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_core_tick <= 1'b0;
      o_periph_tick <= 1'b0;
      o_wdt_tick <= 1'b0;
    end else begin
      o_core_tick <= sys_tick && pm_q == PM_RUN;
      o_periph_tick <= sys_tick && pm_q != PM_SLEEP;
      o_wdt_tick <= i_lf_tick; // see [RULE10]
    end
  end

  assign o_active_src = cur_q;
  assign o_reset_hold = hold_q;
  assign o_startup_busy = st_q != ST_READY;
  assign o_idle = pm_q == PM_IDLE;
  assign o_sleep = pm_q == PM_SLEEP;

  // ----------------------------------------
  // Oscillator pins
  // ----------------------------------------
  logic rc_mode;
  logic co_tick;
  logic [1:0] co_cnt_q;

  assign rc_mode = i_primary_osc_config == scss_pkg::MODE_RC;
  assign co_tick = rc_mode ? i_pri_tick : sys_tick;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      co_cnt_q <= 2'h0;
    end else if (co_tick) begin
      co_cnt_q <= co_cnt_q + 2'h1; // see [RULE12]
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_pins <= '{osc_out: 1'b0, osc_out_oe_n: 1'b1, osc_in_gpio: 1'b0, osc_out_gpio: 1'b0};
    end else begin
      o_pins.osc_out <= co_cnt_q[1];
      o_pins.osc_out_oe_n <= !(rc_mode ||
        i_primary_osc_config == scss_pkg::MODE_INT_OSC_DIVIDED_CLOCK_OUT); // see [RULE12] [RULE17]
      o_pins.osc_in_gpio <= int_mode; // see [RULE17]
      o_pins.osc_out_gpio <= i_primary_osc_config == scss_pkg::MODE_RC_WITH_GPIO ||
        i_primary_osc_config == scss_pkg::MODE_INT_OSC_GPIO; // see [RULE13] [RULE17]
    end
  end

  // ----------------------------------------
  // Register read port
  // ----------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_srst || !i_bus.re) begin
      o_rdata <= 8'h00;
    end else begin
      case (i_bus.addr)
        scss_pkg::ADDR_CTRL: o_rdata <= {idle_sel_q, freq_q, st_q == ST_READY, 1'b0, tgt};
        scss_pkg::ADDR_CTRL2: o_rdata <= {3'h0, midsel_q, 1'b0, cur_q, pend_q};
        scss_pkg::ADDR_TUNE: o_rdata <= {lfsrc_q, 1'b0, tune_q};
        default: o_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_por_timed;
    i_por_event && !i_powerup_timer_enable_n && !i_srst;
  endsequence

  property p_reset_src;
    @(posedge i_clock) i_srst |=> (cur_q == scss_pkg::SRC_PRIMARY) && !pend_q;
  endproperty
  a_reset_src: assert property (p_reset_src) else $error("source not primary after reset"); // see [RULE4]

  property p_reset_freq;
    @(posedge i_clock) i_srst |=> freq_q == scss_pkg::FREQ_RESET;
  endproperty
  a_reset_freq: assert property (p_reset_freq) else $error("frequency not 1 MHz after reset"); // see [RULE7]

  property p_switch_done;
    @(posedge i_clock) disable iff (i_srst)
      pend_q && new_tick && swc_q == SW_LAST && !ctrl_wr |=> !pend_q && cur_q == $past(psrc_q);
  endproperty
  a_switch_done: assert property (p_switch_done) else $error("switch did not complete"); // see [RULE3]

  property p_no_runt;
    @(posedge i_clock) disable iff (i_srst) pend_q |=> !o_core_tick && !o_periph_tick;
  endproperty
  a_no_runt: assert property (p_no_runt) else $error("tick during source transition"); // see [RULE20]

  property p_freq_now;
    @(posedge i_clock) disable iff (i_srst)
      ctrl_wr && wfreq != freq_q |=> hf_cnt_q == 9'h000 && freq_q == $past(wfreq);
  endproperty
  a_freq_now: assert property (p_freq_now) else $error("frequency change delayed"); // see [RULE6]

  property p_sleep;
    @(posedge i_clock) disable iff (i_srst)
      i_sleep_exec && pm_q == PM_RUN && !idle_sel_q ##1 !i_wake |=> o_sleep && !o_core_tick;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not entered"); // see [RULE11]

  property p_pu_hold;
    @(posedge i_clock) disable iff (i_srst) s_por_timed |=> o_reset_hold [*8];
  endproperty
  a_pu_hold: assert property (p_pu_hold) else $error("reset hold released early"); // see [RULE18]

  property p_no_wait;
    @(posedge i_clock) disable iff (i_srst)
      i_por_event && i_powerup_timer_enable_n && !xtal |=> !o_reset_hold && !o_startup_busy;
  endproperty
  a_no_wait: assert property (p_no_wait) else $error("wait added without timer"); // see [RULE19]

  property p_gpio_mode;
    @(posedge i_clock) disable iff (i_srst)
      i_primary_osc_config == scss_pkg::MODE_INT_OSC_GPIO ##1 $stable(i_primary_osc_config)
      |-> o_pins.osc_in_gpio && o_pins.osc_out_gpio && o_pins.osc_out_oe_n;
  endproperty
  a_gpio_mode: assert property (p_gpio_mode) else $error("pins not released"); // see [RULE17]

endmodule
